// file: lpm_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl
  import lpm_pkg::*;
#(
  parameter logic [LPM_DLY_W-1:0] SHORT_CYC = LPM_DLY_SHORT,
  parameter logic [LPM_DLY_W-1:0] LONG_CYC  = LPM_DLY_LONG
)
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire lpm_cpu_req_s       cpu_req,
  input  wire logic               irq_pin_n,
  input  wire logic [3:0]         port_a_irq,
  input  wire logic               ext_reset_n,
  input  wire logic               timer_irq,
  input  wire logic               wdog_timeout,
  output lpm_ctl_s                ctl,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // parameter checks
  // ----------------------------------------------------------------
  // a zero count would underflow the down counter and wait a full wrap
  if (SHORT_CYC == '0) begin : g_bad_short
    $error("short delay count must not be zero");
  end
  if (LONG_CYC < SHORT_CYC) begin : g_bad_long
    $error("long delay count must not be below the short one");
  end

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [LPM_SYNC_W-1:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
  logic                  irq_or_prev_ff, nxt_irq_or_prev;

  always_comb begin
    nxt_sync1 = {ext_reset_n, irq_pin_n, port_a_irq};
    nxt_sync2 = sync1_ff;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= LPM_SYNC_RST;
      sync2_ff <= LPM_SYNC_RST;
    end else begin
      sync1_ff <= nxt_sync1;
      sync2_ff <= nxt_sync2;
    end
  end

  // ----------------------------------------------------------------
  // wake source decode
  // ----------------------------------------------------------------
  logic [LPM_OPT_W-1:0] opt_ff, nxt_opt;
  logic                 rst_pin;
  logic                 irq_or;
  logic                 irq_wake;
  logic                 tmr_wake;
  logic                 wd_hit;

  always_comb begin
    rst_pin  = ~sync2_ff[5];
    // port a inputs are active high, the irq pin active low
    irq_or   = ~sync2_ff[4] | (opt_ff[LPM_OPT_PA_IRQ] & (|sync2_ff[3:0]));
    // edge mode: while one source stays active the others are masked by the or
    irq_wake = opt_ff[LPM_OPT_EDGE_ONLY] ? (irq_or & ~irq_or_prev_ff) : irq_or;
    // the timer request is same-clock logic, so it needs no synchroniser
    tmr_wake = timer_irq;
    wd_hit   = opt_ff[LPM_OPT_WDOG_EN] & wdog_timeout;
    nxt_irq_or_prev = irq_or;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_or_prev_ff <= 1'b0;
    end else begin
      irq_or_prev_ff <= nxt_irq_or_prev;
    end
  end

  // ----------------------------------------------------------------
  // halt-exit phase counter, free running while the oscillator runs
  // ----------------------------------------------------------------
  logic [LPM_DLY_W-1:0] phase_ff, nxt_phase;
  logic [LPM_DLY_W-1:0] dly_len;
  logic                 phase_wrap;

  always_comb begin
    dly_len    = opt_ff[LPM_OPT_LONG_DLY] ? LONG_CYC : SHORT_CYC;
    phase_wrap = (phase_ff >= dly_len - 12'h001);
    nxt_phase  = phase_wrap ? 12'h000 : phase_ff + 12'h001;
    if (!ctl.osc_run) begin
      nxt_phase = 12'h000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_ff <= 12'h000;
    end else begin
      phase_ff <= nxt_phase;
    end
  end

  // ----------------------------------------------------------------
  // mode sequencer
  // ----------------------------------------------------------------
  lpm_state_e           state_ff, nxt_state;
  logic [LPM_DLY_W-1:0] cnt_ff, nxt_cnt;
  logic                 by_rst_ff, nxt_by_rst;
  lpm_ctl_s             ctl_ff, nxt_ctl;
  logic [LPM_EV_W-1:0]  ev;

  always_comb begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_by_rst = by_rst_ff;
    nxt_ctl    = ctl_ff;
    ev         = '0;
    // side-effect strobes last one cycle
    nxt_ctl.clr_timer      = 1'b0;
    nxt_ctl.clr_int_mask   = 1'b0;
    nxt_ctl.set_ext_int_en = 1'b0;
    nxt_ctl.resume_irq     = 1'b0;
    nxt_ctl.cpu_rst        = rst_pin;
    unique case (state_ff)
      LPM_RUN: begin
        if (wd_hit) begin
          nxt_ctl.cpu_rst = 1'b1;
          ev[LPM_EV_WDOG] = 1'b1;
        end else if (rst_pin) begin
          nxt_state = LPM_RUN;
        end else if (cpu_req.stop_req && opt_ff[LPM_OPT_STOP_EN]) begin
          nxt_state              = LPM_STOP;
          nxt_ctl.osc_run        = 1'b0;
          nxt_ctl.cpu_clk_en     = 1'b0;
          nxt_ctl.timer_clk_en   = 1'b0;
          nxt_ctl.wdog_clk_en    = 1'b0;
          // only these three strobes, nothing else is written
          nxt_ctl.clr_timer      = 1'b1;
          nxt_ctl.clr_int_mask   = 1'b1;
          nxt_ctl.set_ext_int_en = 1'b1;
          ev[LPM_EV_STOP]        = 1'b1;
        end else if (cpu_req.stop_req) begin
          // oscillator, timers and watchdog keep running
          nxt_state              = LPM_HALT;
          nxt_ctl.cpu_clk_en     = 1'b0;
          nxt_ctl.clr_int_mask   = 1'b1;
          nxt_ctl.set_ext_int_en = 1'b1;
          ev[LPM_EV_HALT]        = 1'b1;
        end else if (cpu_req.wait_req) begin
          nxt_state              = LPM_WAIT;
          nxt_ctl.cpu_clk_en     = 1'b0;
          nxt_ctl.clr_int_mask   = 1'b1;
          nxt_ctl.set_ext_int_en = 1'b1;
          ev[LPM_EV_WAIT]        = 1'b1;
        end
      end
      LPM_STOP: begin
        // timer and watchdog are frozen, so neither can wake the part
        if (rst_pin || irq_wake) begin
          nxt_state       = LPM_OSCWAIT;
          nxt_by_rst      = rst_pin;
          nxt_cnt         = dly_len - 12'h001;
          nxt_ctl.osc_run = 1'b1;
          ev[LPM_EV_WAKE] = 1'b1;
        end
      end
      LPM_OSCWAIT: begin
        // a reset seen during the restart is kept, so the core never resumes into an interrupt
        nxt_ctl.cpu_rst = by_rst_ff | rst_pin;
        if (rst_pin) begin
          nxt_by_rst = 1'b1;
        end
        if (cnt_ff == 12'h000) begin
          nxt_state            = LPM_RUN;
          nxt_ctl.cpu_clk_en   = 1'b1;
          nxt_ctl.timer_clk_en = 1'b1;
          nxt_ctl.wdog_clk_en  = 1'b1;
          nxt_ctl.resume_irq   = ~(by_rst_ff | rst_pin);
        end else begin
          nxt_cnt = cnt_ff - 12'h001;
        end
      end
      LPM_HALT, LPM_WAIT: begin
        // the watchdog outranks every wake, so a stuck core is always reset
        if (wd_hit) begin
          nxt_state          = LPM_RUN;
          nxt_ctl.cpu_clk_en = 1'b1;
          nxt_ctl.cpu_rst    = 1'b1;
          ev[LPM_EV_WDOG]    = 1'b1;
        end else if (rst_pin || irq_wake || tmr_wake) begin
          nxt_by_rst      = rst_pin;
          ev[LPM_EV_WAKE] = 1'b1;
          if (state_ff == LPM_HALT) begin
            nxt_state = LPM_CLKWAIT;
          end else begin
            nxt_state          = LPM_RUN;
            nxt_ctl.cpu_clk_en = 1'b1;
            nxt_ctl.resume_irq = ~rst_pin;
          end
        end
      end
      LPM_CLKWAIT: begin
        // restart lines up with the free phase counter, so it is never longer than one period
        nxt_ctl.cpu_rst = by_rst_ff | rst_pin;
        if (rst_pin) begin
          nxt_by_rst = 1'b1;
        end
        if (wd_hit) begin
          nxt_state          = LPM_RUN;
          nxt_ctl.cpu_clk_en = 1'b1;
          nxt_ctl.cpu_rst    = 1'b1;
          ev[LPM_EV_WDOG]    = 1'b1;
        end else if (phase_wrap) begin
          nxt_state          = LPM_RUN;
          nxt_ctl.cpu_clk_en = 1'b1;
          nxt_ctl.resume_irq = ~(by_rst_ff | rst_pin);
        end
      end
      default: begin
        nxt_state = LPM_RUN;
        nxt_ctl   = LPM_CTL_RST;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff  <= LPM_RUN;
      cnt_ff    <= 12'h000;
      by_rst_ff <= 1'b0;
      ctl_ff    <= LPM_CTL_RST;
    end else begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      by_rst_ff <= nxt_by_rst;
      ctl_ff    <= nxt_ctl;
    end
  end

  assign ctl = ctl_ff;

  // ----------------------------------------------------------------
  // apb slave and interrupt registers
  // ----------------------------------------------------------------
  logic [LPM_EV_W-1:0] ist_ff, nxt_ist;
  logic [LPM_EV_W-1:0] imask_ff, nxt_imask;
  logic [31:0]         prdata_ff, nxt_prdata;
  logic                pready_ff, nxt_pready;
  logic                pslverr_ff, nxt_pslverr;
  logic                irq_ff, nxt_irq;
  logic                acc;
  logic                wr;
  logic                hit;

  always_comb begin
    // answer comes in the second access cycle; the write lands on that edge
    acc         = psel & penable;
    nxt_pready  = acc & ~pready_ff;
    wr          = acc & pready_ff & pwrite & ~pslverr_ff;
    hit         = (paddr == LPM_OFS_OPTION) | (paddr == LPM_OFS_STATE) |
                  (paddr == LPM_OFS_INT_STAT) | (paddr == LPM_OFS_INT_MASK);
    // unmapped addresses answer with pslverr so stray accesses stay visible
    nxt_pslverr = acc & ~pready_ff & ~hit;
    nxt_prdata  = 32'h0000_0000;
    if (acc && !pready_ff && !pwrite) begin
      unique case (paddr)
        LPM_OFS_OPTION:   nxt_prdata = {27'h000_0000, opt_ff};
        LPM_OFS_STATE:    nxt_prdata = {28'h000_0000, by_rst_ff, state_ff};
        LPM_OFS_INT_STAT: nxt_prdata = {27'h000_0000, ist_ff};
        LPM_OFS_INT_MASK: nxt_prdata = {27'h000_0000, imask_ff};
        default:          nxt_prdata = 32'h0000_0000;
      endcase
    end
    nxt_opt   = opt_ff;
    nxt_imask = imask_ff;
    nxt_ist   = ist_ff;
    if (wr && paddr == LPM_OFS_OPTION) begin
      nxt_opt = pwdata[LPM_OPT_W-1:0];
    end
    if (wr && paddr == LPM_OFS_INT_MASK) begin
      nxt_imask = pwdata[LPM_EV_W-1:0];
    end
    if (wr && paddr == LPM_OFS_INT_STAT) begin
      nxt_ist = ist_ff & ~pwdata[LPM_EV_W-1:0];
    end
    // a new event beats a clear in the same cycle
    nxt_ist = nxt_ist | ev;
    nxt_irq = |(nxt_ist & nxt_imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_ff     <= LPM_OPT_RST;
      ist_ff     <= LPM_EV_RST;
      imask_ff   <= LPM_EV_RST;
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      opt_ff     <= nxt_opt;
      ist_ff     <= nxt_ist;
      imask_ff   <= nxt_imask;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff     <= nxt_irq;
    end
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;
  assign irq     = irq_ff;

endmodule
`default_nettype wire

// file: lpm_pkg.sv
package lpm_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] LPM_OFS_OPTION   = 8'h00;
  localparam logic [7:0] LPM_OFS_STATE    = 8'h04;
  localparam logic [7:0] LPM_OFS_INT_STAT = 8'h08;
  localparam logic [7:0] LPM_OFS_INT_MASK = 8'h0C;

  // option register fields
  localparam int LPM_OPT_STOP_EN   = 0;
  localparam int LPM_OPT_LONG_DLY  = 1;
  localparam int LPM_OPT_PA_IRQ    = 2;
  localparam int LPM_OPT_EDGE_ONLY = 3;
  localparam int LPM_OPT_WDOG_EN   = 4;
  localparam int LPM_OPT_W         = 5;
  localparam logic [LPM_OPT_W-1:0] LPM_OPT_RST = 5'h01;

  // interrupt status / mask fields
  localparam int LPM_EV_STOP  = 0;
  localparam int LPM_EV_HALT  = 1;
  localparam int LPM_EV_WAIT  = 2;
  localparam int LPM_EV_WAKE  = 3;
  localparam int LPM_EV_WDOG  = 4;
  localparam int LPM_EV_W     = 5;
  localparam logic [LPM_EV_W-1:0] LPM_EV_RST = 5'h00;

  // ----------------------------------------------------------------
  // timing, in processor clock cycles
  // ----------------------------------------------------------------
  localparam int            LPM_DLY_W     = 12;
  localparam logic [11:0]   LPM_DLY_SHORT = 12'h010;
  localparam logic [11:0]   LPM_DLY_LONG  = 12'hFE0;
  localparam int            LPM_SYNC_W    = 6;
  // synchroniser reset: reset and irq pins high, port a low, all inactive
  localparam logic [LPM_SYNC_W-1:0] LPM_SYNC_RST = 6'h30;

  typedef enum logic [2:0] {
    LPM_RUN     = 3'b000,
    LPM_STOP    = 3'b001,
    LPM_HALT    = 3'b010,
    LPM_WAIT    = 3'b011,
    LPM_OSCWAIT = 3'b100,
    LPM_CLKWAIT = 3'b101
  } lpm_state_e;

  // instruction requests from the cpu core
  typedef struct packed {
    logic stop_req;
    logic wait_req;
  } lpm_cpu_req_s;

  // clock gates and register side effects
  typedef struct packed {
    logic osc_run;
    logic cpu_clk_en;
    logic timer_clk_en;
    logic wdog_clk_en;
    logic clr_timer;
    logic clr_int_mask;
    logic set_ext_int_en;
    logic resume_irq;
    logic cpu_rst;
  } lpm_ctl_s;

  localparam lpm_ctl_s LPM_CTL_RST = '{osc_run: 1'b1, cpu_clk_en: 1'b1, timer_clk_en: 1'b1,
                                       wdog_clk_en: 1'b1, clr_timer: 1'b0, clr_int_mask: 1'b0,
                                       set_ext_int_en: 1'b0, resume_irq: 1'b0, cpu_rst: 1'b0};

endpackage

// file: lpm_ctrl_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module lpm_ctrl_monitor
  import lpm_pkg::*;
(
  input wire logic         pclk,
  input wire logic         presetn,
  input wire lpm_cpu_req_s cpu_req,
  input wire logic         irq_pin_n,
  input wire logic [3:0]   port_a_irq,
  input wire logic         ext_reset_n,
  input wire logic         timer_irq,
  input wire lpm_ctl_s     ctl
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------
  // sleep tracking
  // ------
  logic        stop_ff;
  logic        wk_ff;
  logic [12:0] cnt_ff;
  logic        ext_wk;
  // port a counted even when its option is off: looser for a_stop_wake, but a_nap_bound can fire if it stays high in halt or wait
  assign ext_wk = !irq_pin_n || (|port_a_irq) || !ext_reset_n;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stop_ff <= 1'b0;
      wk_ff   <= 1'b0;
      cnt_ff  <= 13'h0;
    end else begin
      stop_ff <= !ctl.cpu_clk_en && (stop_ff || !ctl.osc_run);
      wk_ff   <= !ctl.cpu_clk_en && (wk_ff || ext_wk || (!stop_ff && ctl.osc_run && timer_irq));
      cnt_ff  <= ctl.cpu_clk_en ? 13'h0 : cnt_ff + 13'((ctl.osc_run && (stop_ff || wk_ff)) ? 1 : 0);
    end
  end
  // ------
  // properties
  // ------
  property p_stop_off; !ctl.osc_run |-> !ctl.cpu_clk_en && !ctl.timer_clk_en && !ctl.wdog_clk_en; endproperty
  a_stop_off: assert property (p_stop_off) else $error("clock left on in stop");
  property p_stop_side; ctl.clr_timer |-> ctl.clr_int_mask && ctl.set_ext_int_en && !ctl.osc_run; endproperty
  a_stop_side: assert property (p_stop_side) else $error("stop entry strobes wrong");
  property p_clr_cause; ctl.clr_timer |-> $past(cpu_req.stop_req); endproperty
  a_clr_cause: assert property (p_clr_cause) else $error("timer cleared without stop");
  property p_stop_wake; $rose(ctl.osc_run) |-> wk_ff; endproperty
  a_stop_wake: assert property (p_stop_wake) else $error("stop left without wake source");
  property p_stop_dly; $rose(ctl.cpu_clk_en) && stop_ff |-> cnt_ff inside {[15:17], [4063:4065]}; endproperty
  a_stop_dly: assert property (p_stop_dly) else $error("oscillator delay wrong");
  property p_nap_clk; ctl.osc_run && !stop_ff |-> ctl.timer_clk_en && ctl.wdog_clk_en; endproperty
  a_nap_clk: assert property (p_nap_clk) else $error("timer clock off outside stop");
  property p_nap_side; $fell(ctl.cpu_clk_en) && ctl.osc_run |-> ctl.clr_int_mask && ctl.set_ext_int_en && !ctl.clr_timer;
  endproperty
  a_nap_side: assert property (p_nap_side) else $error("halt or wait strobes wrong");
  property p_nap_bound; !stop_ff |-> cnt_ff <= 13'd4070; endproperty
  a_nap_bound: assert property (p_nap_bound) else $error("wake from halt or wait too slow");
  property p_pin_rst; !ext_reset_n [*5] |-> ctl.cpu_rst; endproperty
  a_pin_rst: assert property (p_pin_rst) else $error("reset pin not followed");
  property p_resume; ctl.resume_irq |-> ctl.cpu_clk_en && !ctl.cpu_rst; endproperty
  a_resume: assert property (p_resume) else $error("resume without running clock");
  c_stop: cover property (ctl.clr_timer);
  c_rst: cover property ($rose(ctl.cpu_rst));
  c_resume: cover property (ctl.resume_irq);
endmodule
bind lpm_ctrl lpm_ctrl_monitor mon_u (.pclk(pclk), .presetn(presetn), .cpu_req(cpu_req), .irq_pin_n(irq_pin_n),
  .port_a_irq(port_a_irq), .ext_reset_n(ext_reset_n), .timer_irq(timer_irq), .ctl(ctl));
`default_nettype wire

// file: lpm_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module lpm_core_model
  import lpm_pkg::*;
(
  input  wire logic     pclk,
  input  wire lpm_ctl_s ctl,
  output lpm_cpu_req_s  cpu_req
);
  int irq_seen;
  int rst_seen;
  initial begin
    cpu_req  = '0;
    irq_seen = 0;
    rst_seen = 0;
  end
  // a sleeping core fetches nothing, so no instruction before the clock is back
  task automatic issue(input logic is_stop);
    int n;
    n = 0;
    while (ctl.cpu_clk_en !== 1'b1 && n < 6000) begin
      @(posedge pclk);
      n++;
    end
    @(posedge pclk);
    cpu_req <= '{stop_req: is_stop, wait_req: !is_stop};
    @(posedge pclk);
    cpu_req <= '0;
  endtask
  // counted mid-cycle, so a check at the next rising edge never races the count
  always @(negedge pclk) begin
    if (ctl.resume_irq === 1'b1) irq_seen++;
    if (ctl.cpu_rst === 1'b1) rst_seen++;
  end
endmodule
`default_nettype wire

// file: low_power_mode_control_tb.sv
`timescale 1ns/100ps
`default_nettype none
module low_power_mode_control_tb;
  import lpm_pkg::*;
  localparam logic [8:0] STOP_CTL = 9'h01C;
  localparam logic [8:0] NAP_CTL  = 9'h16C;
  logic         pclk = 1'b0;
  logic         presetn, psel, penable, pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, q;
  logic         pready, pslverr, er, irq, irq_pin_n, ext_reset_n, timer_irq, wdog_timeout;
  logic [3:0]   port_a_irq;
  lpm_cpu_req_s cpu_req;
  lpm_ctl_s     ctl;
  int           bad_count = 0;
  int           total_checks = 0;
  int           wake_n = 0;
  always #5 pclk = ~pclk;
  lpm_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cpu_req(cpu_req),
    .irq_pin_n(irq_pin_n), .port_a_irq(port_a_irq), .ext_reset_n(ext_reset_n), .timer_irq(timer_irq),
    .wdog_timeout(wdog_timeout), .ctl(ctl), .irq(irq));
  lpm_core_model core_u (.pclk(pclk), .ctl(ctl), .cpu_req(cpu_req));
  // ------
  // tasks
  // ------
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q       = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("register", e, q);
  endtask
  task automatic till_run();
    int n;
    n = 0;
    while (ctl.cpu_clk_en !== 1'b1 && n < 6000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 6000) bad_count++;
    wake_n = n;
  endtask
  // strobes stand one cycle, so they are looked at in that very cycle
  task automatic enter(input logic s, input logic [8:0] e);
    core_u.issue(s);
    #1 chk("entry ctl", 32'(e), 32'(ctl));
    @(posedge pclk);
  endtask
  task automatic pulse_timer();
    timer_irq <= 1'b1;
    @(posedge pclk) timer_irq <= 1'b0;
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #300us;
    bad_count++;
    finish_test();
  end
  // ------
  // tests
  // ------
  initial begin
    {presetn, psel, penable, pwrite, timer_irq, wdog_timeout} = '0;
    {irq_pin_n, ext_reset_n} = 2'b11;
    {paddr, pwdata, port_a_irq} = '0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk("reset ctl", 32'(LPM_CTL_RST), 32'(ctl));
    rd(LPM_OFS_OPTION, 32'(LPM_OPT_RST));
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, 32'(er));
    apb(1'b1, LPM_OFS_INT_MASK, 32'h1F);
    $display("test reset done");
    enter(1'b1, STOP_CTL);
    timer_irq  <= 1'b1;
    port_a_irq <= 4'hF;
    repeat (30) @(posedge pclk);
    chk("asleep", 32'h0, 32'(ctl.osc_run));
    rd(LPM_OFS_STATE, 32'h1);
    {timer_irq, port_a_irq} <= '0;
    irq_pin_n <= 1'b0;
    till_run();
    irq_pin_n <= 1'b1;
    chk("resume", 32'h1, 32'(core_u.irq_seen));
    rd(LPM_OFS_INT_STAT, 32'h09);
    chk("irq", 32'h1, 32'(irq));
    apb(1'b1, LPM_OFS_INT_STAT, 32'h1F);
    chk("irq cleared", 32'h0, 32'(irq));
    $display("test stop done");
    apb(1'b1, LPM_OFS_OPTION, 32'h0);
    enter(1'b1, NAP_CTL);
    pulse_timer();
    till_run();
    chk("halt resume", 32'h2, 32'(core_u.irq_seen));
    chk("halt delay", 32'h1, 32'(wake_n <= 17));
    enter(1'b0, NAP_CTL);
    pulse_timer();
    till_run();
    chk("wait resume", 32'h3, 32'(core_u.irq_seen));
    chk("wait delay", 32'h1, 32'(wake_n));
    $display("test halt and wait done");
    apb(1'b1, LPM_OFS_OPTION, 32'h07);
    enter(1'b1, STOP_CTL);
    port_a_irq <= 4'h2;
    till_run();
    port_a_irq <= 4'h0;
    chk("port a resume", 32'h4, 32'(core_u.irq_seen));
    chk("stop delay", 32'(LPM_DLY_LONG) + 32'd4, 32'(wake_n));
    rd(LPM_OFS_STATE, 32'h0);
    $display("test long stop done");
    port_a_irq <= 4'h1;
    apb(1'b1, LPM_OFS_OPTION, 32'h1D);
    enter(1'b1, STOP_CTL);
    port_a_irq   <= 4'h3;
    wdog_timeout <= 1'b1;
    repeat (8) @(posedge pclk);
    wdog_timeout <= 1'b0;
    chk("edge held", 32'h0, 32'(ctl.osc_run));
    port_a_irq <= 4'h0;
    repeat (4) @(posedge pclk);
    port_a_irq <= 4'h8;
    till_run();
    port_a_irq <= 4'h0;
    chk("edge resume", 32'h5, 32'(core_u.irq_seen));
    $display("test edge wake done");
    apb(1'b1, LPM_OFS_OPTION, 32'h10);
    apb(1'b1, LPM_OFS_INT_STAT, 32'h1F);
    enter(1'b0, NAP_CTL);
    wdog_timeout <= 1'b1;
    @(posedge pclk) wdog_timeout <= 1'b0;
    till_run();
    chk("wdog reset", 32'h1, 32'(core_u.rst_seen));
    rd(LPM_OFS_INT_STAT, 32'h14);
    enter(1'b0, NAP_CTL);
    ext_reset_n <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("pin reset", 32'h1, 32'(ctl.cpu_rst));
    ext_reset_n <= 1'b1;
    till_run();
    repeat (6) @(posedge pclk);
    chk("reset released", 32'h0, 32'(ctl.cpu_rst));
    $display("test watchdog and reset done");
    finish_test();
  end
endmodule
`default_nettype wire
